// ---- rtl/ext0_defs.svh ----
// Purpose: register offsets, field positions and reset values of the pin-0 interrupt block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   offsets are byte addresses
`ifndef EXT0_DEFS_SVH
`define EXT0_DEFS_SVH

`define EXT0_CTRL_OFS      8'h00
`define EXT0_IEN_OFS       8'h04
`define EXT0_FLAG_OFS      8'h08
`define EXT0_SKIP_OFS      8'h0c
`define EXT0_ISTAT_OFS     8'h10
`define EXT0_IMASK_OFS     8'h14
`define EXT0_PORT_OFS      8'h18
`define EXT0_WAKE_OFS      8'h1c

`define EXT0_CTRL_EN_BIT   3
`define EXT0_CTRL_RISE_BIT 2
`define EXT0_CTRL_BOTH_BIT 1
`define EXT0_CTRL_SYNC_BIT 0
`define EXT0_IEN_BIT       0
`define EXT0_PORT_OUT_BIT  0
`define EXT0_PORT_OE_BIT   1

`define EXT0_CTRL_RST      4'h0
`define EXT0_ISTAT_W       2
`define EXT0_IST_RST       2'h0

`endif

// ---- rtl/ext0_pkg.sv ----
// Purpose: shared types of the pin-0 interrupt block
// Assumes: nothing beyond the defs header
// Notes:   field order of pin0_ctrl_s matches the control register bits 3..0
package ext0_pkg;

  typedef struct packed {
    logic in_en;
    logic wave_rise;
    logic both_edges;
    logic timer_sync;
  } pin0_ctrl_s;

  typedef struct packed {
    logic detect;
    logic by_ctrl;
  } pin0_event_s;

endpackage

// ---- rtl/ext0_edge_detect.sv ----
// Purpose: valid-waveform detector for interrupt pin 0
// Assumes: pin input is synchronous to pclk
// Notes:   in single-edge mode control changes act on the detector like pin changes do; in both-edge mode only pin changes count
`timescale 1ns/10ps
module ext0_edge_detect
  import ext0_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pin,
  input  pin0_ctrl_s       ctrl,
  output pin0_event_s      ev
);

  logic prev_eff;
  logic prev_pin;
  logic prev_en;
  wire  eff;
  wire  one_edge;
  wire  any_edge;
  wire  hit;

  // level seen through enable and polarity; a control write can make it rise
  assign eff      = ctrl.in_en & (pin ~^ ctrl.wave_rise);
  assign one_edge = eff & ~prev_eff;
  assign any_edge = ctrl.in_en & prev_en & (pin ^ prev_pin);
  assign hit      = ctrl.both_edges ? any_edge : one_edge;
  assign ev       = '{detect: hit, by_ctrl: hit & (pin == prev_pin)};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_eff <= 1'b0;
      prev_pin <= 1'b0;
      prev_en  <= 1'b0;
    end else begin
      prev_eff <= eff;
      prev_pin <= pin;
      prev_en  <= ctrl.in_en;
    end
  end

endmodule

// ---- rtl/ext0_irq_ctrl.sv ----
// Purpose: external interrupt pin 0 control with APB register access
// Assumes: pin input synchronous to pclk; APB slave with no wait state
// Notes:   the skip register read stands in for the skip-on-flag instruction
//
// Functional notes
// - enable bit write may set request flag
// - waveform bit write may set request flag
// - enable bit zero ignores pin input
// - skip read clears flag; software adds no-op
// - shared port output usable while pin selected
`timescale 1ns/10ps
`include "ext0_defs.svh"
module ext0_irq_ctrl
  import ext0_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ext_irq_pin_zero,
  output logic                   shared_port_bit_out,
  output logic                   shared_port_bit_oe,
  output logic                   wakeup_req,
  output logic                   irq
);

  if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_check
    $error("ADDR_W must lie between 5 and 32");
  end

  pin0_ctrl_s                 ctrl;
  logic                       interrupt_enable_reg;
  logic                       ext0_request_flag;
  logic [`EXT0_ISTAT_W-1:0]   istat;
  logic [`EXT0_ISTAT_W-1:0]   imask;
  logic                       port_out;
  logic                       port_oe;
  logic                       pin0_keyon_wakeup_bit;
  logic                       skip_cap;
  pin0_event_s                ev;

  logic [`EXT0_ISTAT_W-1:0]   next_istat;
  logic                       next_flag;
  logic [31:0]                next_rdata;

  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire wr_acc   = access & pwrite;
  wire rd_setup = setup & ~pwrite;
  wire sel_ctrl  = paddr == ADDR_W'(`EXT0_CTRL_OFS);
  wire sel_ien   = paddr == ADDR_W'(`EXT0_IEN_OFS);
  wire sel_flag  = paddr == ADDR_W'(`EXT0_FLAG_OFS);
  wire sel_skip  = paddr == ADDR_W'(`EXT0_SKIP_OFS);
  wire sel_istat = paddr == ADDR_W'(`EXT0_ISTAT_OFS);
  wire sel_imask = paddr == ADDR_W'(`EXT0_IMASK_OFS);
  wire sel_port  = paddr == ADDR_W'(`EXT0_PORT_OFS);
  wire sel_wake  = paddr == ADDR_W'(`EXT0_WAKE_OFS);
  wire hit = sel_ctrl | sel_ien | sel_flag | sel_skip | sel_istat | sel_imask | sel_port | sel_wake;
  wire ctrl_wr  = wr_acc & sel_ctrl;
  // the skip answer is taken in setup so the clear lines up with the data returned
  wire skip_ok  = ext0_request_flag & ~interrupt_enable_reg;
  wire skip_clr = access & ~pwrite & sel_skip & skip_cap;
  wire accept   = ext0_request_flag & interrupt_enable_reg;
  wire [`EXT0_ISTAT_W-1:0] w1c = (wr_acc & sel_istat) ? pwdata[`EXT0_ISTAT_W-1:0] : '0;
  wire [`EXT0_ISTAT_W-1:0] new_ev = {ev.by_ctrl, accept};
  wire [`EXT0_ISTAT_W-1:0] next_imask = (wr_acc & sel_imask) ? pwdata[`EXT0_ISTAT_W-1:0] : imask;

  assign pready  = 1'b1;
  assign pslverr = access & ~hit;

  ext0_edge_detect u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (ext_irq_pin_zero),
    .ctrl    (ctrl),
    .ev      (ev)
  );

  // set wins over both clears; an accepted request moves into the status register
  assign next_flag  = ev.detect | (ext0_request_flag & ~accept & ~skip_clr);
  assign next_istat = (istat & ~w1c) | new_ev;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (sel_ctrl) begin
      next_rdata[3:0] = ctrl;
    end else if (sel_ien) begin
      next_rdata[`EXT0_IEN_BIT] = interrupt_enable_reg;
    end else if (sel_flag) begin
      next_rdata[1:0] = {ext_irq_pin_zero, ext0_request_flag};
    end else if (sel_skip) begin
      next_rdata[0] = skip_ok;
    end else if (sel_istat) begin
      next_rdata[`EXT0_ISTAT_W-1:0] = istat;
    end else if (sel_imask) begin
      next_rdata[`EXT0_ISTAT_W-1:0] = imask;
    end else if (sel_port) begin
      next_rdata[1:0] = {port_oe, port_out};
    end else if (sel_wake) begin
      next_rdata[0] = pin0_keyon_wakeup_bit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata   <= 32'h0000_0000;
      skip_cap <= 1'b0;
    end else if (rd_setup) begin
      prdata   <= next_rdata;
      skip_cap <= sel_skip & skip_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl                  <= `EXT0_CTRL_RST;
      interrupt_enable_reg  <= 1'b0;
      port_out              <= 1'b0;
      port_oe               <= 1'b0;
      pin0_keyon_wakeup_bit <= 1'b0;
    end else if (wr_acc) begin
      if (sel_ctrl) ctrl <= pwdata[3:0];
      if (sel_ien) interrupt_enable_reg <= pwdata[`EXT0_IEN_BIT];
      if (sel_port) begin
        port_out <= pwdata[`EXT0_PORT_OUT_BIT];
        port_oe  <= pwdata[`EXT0_PORT_OE_BIT];
      end
      if (sel_wake) pin0_keyon_wakeup_bit <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext0_request_flag <= 1'b0;
      istat             <= `EXT0_IST_RST;
      imask             <= `EXT0_IST_RST;
      irq               <= 1'b0;
      wakeup_req        <= 1'b0;
    end else begin
      ext0_request_flag <= next_flag;
      istat             <= next_istat;
      imask             <= next_imask;
      irq               <= |(next_istat & next_imask);
      wakeup_req        <= pin0_keyon_wakeup_bit & ev.detect;
    end
  end

  // port latch drives the pin whatever the interrupt selection is
  assign shared_port_bit_out = port_out;
  assign shared_port_bit_oe  = port_oe;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pin_steady;
    $stable(ext_irq_pin_zero) && !ctrl_wr;
  endsequence

  sequence s_enable_write;
    ctrl_wr && !ctrl.in_en && pwdata[3] && !pwdata[1] && (ext_irq_pin_zero == pwdata[2]);
  endsequence

  sequence s_wave_write;
    ctrl_wr && ctrl.in_en && !ctrl.both_edges && pwdata[3] && !pwdata[1]
      && (pwdata[2] != ctrl.wave_rise) && (ext_irq_pin_zero == pwdata[2]);
  endsequence

  en_write_sets_a: assert property (s_enable_write ##1 s_pin_steady |=> ext0_request_flag || istat[0])
    else $error("enable write did not set request flag");

  wave_write_sets_a: assert property (s_wave_write ##1 s_pin_steady |=> ext0_request_flag || istat[0])
    else $error("waveform write did not set request flag");

  pin_ignored_a: assert property (!ctrl.in_en && !ctrl_wr && !ext0_request_flag |=> !ext0_request_flag)
    else $error("request flag set while input disabled");

  skip_answer_a: assert property (rd_setup && sel_skip && skip_ok |=> prdata[0] ##0 skip_cap)
    else $error("skip read did not report set flag");

  skip_clears_a: assert property (skip_clr && !ev.detect |=> !ext0_request_flag)
    else $error("skip read did not clear request flag");

  set_wins_a: assert property (skip_clr && ev.detect |=> ext0_request_flag)
    else $error("flag set lost against skip clear");

  port_usable_a: assert property (wr_acc && sel_port && ctrl.in_en |=> shared_port_bit_out == $past(pwdata[0]))
    else $error("port output blocked by interrupt selection");

  flag_to_irq_a: assert property (ext0_request_flag && interrupt_enable_reg && imask[0] && !(wr_acc && sel_imask)
      |=> irq ##0 istat[0])
    else $error("enabled request did not raise interrupt");

  // the flag only leaves through a skip clear, and no new accepted status appears
  no_irq_off_a: assert property (ext0_request_flag && !interrupt_enable_reg && !(wr_acc && sel_ien)
      |=> (ext0_request_flag || $past(skip_clr)) && (!istat[0] || $past(istat[0])))
    else $error("request became interrupt while disabled");

  irq_level_a: assert property (irq == |(istat & imask))
    else $error("interrupt output disagrees with masked status");

  input_off_quiet_a: assert property (!ctrl.in_en |-> !ev.detect)
    else $error("waveform detected while input disabled");

  wake_pulse_a: assert property (pin0_keyon_wakeup_bit && ev.detect |=> wakeup_req)
    else $error("key-on wakeup request missing after detection");

  unmapped_error_a: assert property (access && !hit |-> pslverr)
    else $error("unmapped access did not signal an error");

  detect_sets_a: assert property (ev.detect |=> ext0_request_flag || istat[0])
    else $error("detected waveform did not set flag");

endmodule

// ---- tb/pin_source.sv ----
// Purpose: outside signal source that drives interrupt pin 0
// Assumes: the bench commands each new level just after a rising edge
// Notes:   one flop; the source shares the board clock, so the pin is synchronous
`timescale 1ns/10ps
module pin_source (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic level,
  output logic      pin
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin <= 1'b0;
    else pin <= level;
  end
endmodule

// ---- tb/test_external_interrupt0_pin_control.sv ----
// Purpose: self-checking bench of the pin-0 interrupt block over APB
// Assumes: zero-wait APB slave; pin source one flop behind the level command
// Notes:   software precautions are kept by the order of the bus writes
`timescale 1ns/10ps
`include "ext0_defs.svh"
module test_external_interrupt0_pin_control;
  logic        pclk, presetn, psel, penable, pwrite, level, pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, port_out, port_oe, err, irq, wake;
  int          n_fail, comparisons, cycles, n_wake;

  pin_source src (.pclk(pclk), .presetn(presetn), .level(level), .pin(pin));
  ext0_irq_ctrl #(.ADDR_W(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin_zero(pin), .shared_port_bit_out(port_out), .shared_port_bit_oe(port_oe),
    .wakeup_req(wake), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // request held from setup until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic t_enable_write;
    xfer(1'b1, `EXT0_IEN_OFS, 32'h0);
    xfer(1'b1, `EXT0_CTRL_OFS, 32'h8);
    settle(4);
    rchk(`EXT0_FLAG_OFS, 32'h1);
    rchk(`EXT0_SKIP_OFS, 32'h1);
    rchk(`EXT0_SKIP_OFS, 32'h0);
    rchk(`EXT0_FLAG_OFS, 32'h0);
    $display("test enable_write done");
  endtask

  task automatic t_wave_write;
    level <= 1'b1;
    settle(4);
    rchk(`EXT0_FLAG_OFS, 32'h2);
    xfer(1'b1, `EXT0_CTRL_OFS, 32'hc);
    settle(4);
    rchk(`EXT0_FLAG_OFS, 32'h3);
    rchk(`EXT0_SKIP_OFS, 32'h1);
    $display("test wave_write done");
  endtask

  task automatic t_backup;
    xfer(1'b1, `EXT0_CTRL_OFS, 32'h0);
    level <= 1'b0;
    settle(4);
    level <= 1'b1;
    settle(4);
    rchk(`EXT0_FLAG_OFS, 32'h2);
    rchk(`EXT0_SKIP_OFS, 32'h0);
    $display("test backup done");
  endtask

  task automatic t_irq;
    level <= 1'b0;
    xfer(1'b1, `EXT0_ISTAT_OFS, 32'h3);
    rchk(`EXT0_ISTAT_OFS, 32'h0);
    xfer(1'b1, `EXT0_CTRL_OFS, 32'hc);
    xfer(1'b1, `EXT0_IMASK_OFS, 32'h1);
    xfer(1'b1, `EXT0_IEN_OFS, 32'h1);
    settle(2);
    chk(irq, 1'b0);
    level <= 1'b1;
    settle(6);
    chk(irq, 1'b1);
    rchk(`EXT0_ISTAT_OFS, 32'h1);
    rchk(`EXT0_FLAG_OFS, 32'h2);
    xfer(1'b1, `EXT0_ISTAT_OFS, 32'h1);
    settle(2);
    chk(irq, 1'b0);
    // masked event: sticky status but no interrupt
    xfer(1'b1, `EXT0_IMASK_OFS, 32'h0);
    level <= 1'b0;
    settle(3);
    level <= 1'b1;
    settle(6);
    chk(irq, 1'b0);
    rchk(`EXT0_ISTAT_OFS, 32'h1);
    xfer(1'b1, `EXT0_IEN_OFS, 32'h0);
    $display("test irq done");
  endtask

  // wakeup pulses last one cycle, so they are counted as they pass
  always @(posedge pclk) begin
    if (wake === 1'b1) n_wake++;
  end

  task automatic t_wakeup_both;
    chk(n_wake, 0);
    xfer(1'b1, `EXT0_WAKE_OFS, 32'h1);
    rchk(`EXT0_WAKE_OFS, 32'h1);
    xfer(1'b1, `EXT0_CTRL_OFS, 32'hb);
    rchk(`EXT0_CTRL_OFS, 32'hb);
    rchk(`EXT0_SKIP_OFS, 32'h0);
    level <= 1'b0;
    settle(4);
    level <= 1'b1;
    settle(4);
    chk(n_wake, 2);
    rchk(`EXT0_FLAG_OFS, 32'h3);
    rchk(`EXT0_SKIP_OFS, 32'h1);
    $display("test wakeup_both done");
  endtask

  task automatic t_port_and_bus;
    xfer(1'b1, `EXT0_PORT_OFS, 32'h3);
    settle(1);
    chk({port_oe, port_out}, 2'h3);
    rchk(`EXT0_PORT_OFS, 32'h3);
    xfer(1'b1, 8'h20, 32'hffff_ffff);
    chk(err, 1'b1);
    rchk(8'h20, 32'h0);
    chk(err, 1'b1);
    $display("test port_and_bus done");
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // the whole run needs under two hundred cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    n_fail = 0; comparisons = 0; cycles = 0; n_wake = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; level = 1'b0;
    settle(3);
    presetn <= 1'b1;
    chk({irq, pready}, 2'h1);
    rchk(`EXT0_CTRL_OFS, 32'h0);
    t_enable_write();
    t_wave_write();
    t_backup();
    t_irq();
    t_wakeup_both();
    t_port_and_bus();
    close_out();
  end
endmodule
